/* hdl/lmon_pkg.sv */
// Shared constants and types of the liveness monitor
package lmon_pkg;

  // ----------------------------------------------------------------------
  // Clocking and tick generation
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned SLOW_OSC_HZ   = 20_000;      // Keep-alive oscillator
  localparam int unsigned FAST_OSC_HZ   = 48_000_000;  // Relaxation oscillator
  // Slow tick period in system clocks, rounded down, at least one
  localparam int unsigned SLOW_DIV      = (CLK_HZ / SLOW_OSC_HZ < 1) ? 1 : CLK_HZ / SLOW_OSC_HZ;
  localparam int unsigned TICK_W        = 16;

  // ----------------------------------------------------------------------
  // Interval counter
  // ----------------------------------------------------------------------
  localparam int unsigned CNT_W         = 16;
  localparam logic [15:0] INTERVAL_RST  = 16'h0100;
  localparam logic [15:0] COUNT_RST     = 16'h0000;

  // Reset pulse length in system clocks
  localparam int unsigned RST_PULSE_CYC = 16;
  localparam logic [4:0]  PULSE_RST     = 5'h00;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic {LMON_RES_SLOW, LMON_RES_FAST} lmon_res_t;
  typedef enum logic [1:0] {LMON_IDLE, LMON_RUN, LMON_FIRE} lmon_state_t;

endpackage : lmon_pkg

/* hdl/lmon_tick_if.sv */
// Carrier of the count tick between the tick source and the monitor
`timescale 1ns/1ps
interface lmon_tick_if;
  logic tick;
  logic fast_sel;
  modport source (output tick, input fast_sel);
  modport sink   (input tick, output fast_sel);
endinterface : lmon_tick_if

/* hdl/lmon_tick.sv */
// Count tick source: slow oscillator divider or synchronised fast oscillator
`timescale 1ns/1ps
module lmon_tick (
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       reset_n_in,
  // Fast oscillator pin, outside the clock domain
  input  wire logic       fast_osc_in,
  // Tick carrier
  lmon_tick_if.source     tick_bus
);

  logic [lmon_pkg::TICK_W-1:0] div_cnt;
  logic                        osc_s1;
  logic                        osc_s2;
  logic                        osc_s3;
  wire                         slow_wrap;
  wire                         fast_edge;

  // Tick select: slow divider wrap or fast oscillator edge
  assign slow_wrap = (div_cnt == lmon_pkg::TICK_W'(lmon_pkg::SLOW_DIV - 1));
  assign fast_edge = osc_s2 & ~osc_s3;

  // Slow divider, fast pin synchroniser and tick register
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      div_cnt       <= '0;
      osc_s1        <= 1'b0;
      osc_s2        <= 1'b0;
      osc_s3        <= 1'b0;
      tick_bus.tick <= 1'b0;
    end else begin
      div_cnt       <= slow_wrap ? '0 : div_cnt + 1'b1;
      osc_s1        <= fast_osc_in;
      osc_s2        <= osc_s1;
      osc_s3        <= osc_s2;
      tick_bus.tick <= tick_bus.fast_sel ? fast_edge : slow_wrap;
    end
  end

endmodule : lmon_tick

/* hdl/lmon_top.sv */
// Liveness monitor: interval counter, forced reset, expiry flag and write gate
`timescale 1ns/1ps
module lmon_top #(
  // Forced reset pulse length in system clocks
  parameter int unsigned PULSE_CYC = lmon_pkg::RST_PULSE_CYC
) (
  // Clock and reset
  input  wire logic                 clock_in,
  input  wire logic                 reset_n_in,
  // Configuration
  input  wire logic                 enable_in,
  input  wire logic                 fast_res_in,
  input  wire logic [15:0]          interval_in,
  // Software service
  input  wire logic                 reload_in,
  input  wire logic                 irq_clear_in,
  // Fast oscillator pin
  input  wire logic                 fast_osc_in,
  // Host serial write path
  input  wire logic                 host_wr_in,
  output logic                      host_wr_ok_out,
  // Results
  output logic                      sys_reset_out,
  output logic                      expiry_irq_out,
  output logic [15:0]               count_out
);

  lmon_tick_if tick_bus ();

  lmon_pkg::lmon_state_t state;
  lmon_pkg::lmon_state_t next_state;
  logic [lmon_pkg::CNT_W-1:0] count;
  logic [lmon_pkg::CNT_W-1:0] next_count;
  logic [4:0]                 pulse;
  logic                       expiry;
  wire                        expire_hit;
  wire                        pulse_done;
  wire [lmon_pkg::CNT_W:0]    count_inc;
  logic [5:0]                 pulse_seen;

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  // Pulse counter is five bits; the pulse assertion needs eight cycles
  if (PULSE_CYC < 8 || PULSE_CYC > 32) begin : g_bad_pulse
    $error("reset pulse length out of range");
  end

  // Count width must match the interval and count ports
  if (lmon_pkg::CNT_W != 16) begin : g_bad_width
    $error("count width must match the 16 bit ports");
  end

  // Count plus one, a bit wider so the compare cannot wrap
  function automatic logic [lmon_pkg::CNT_W:0] count_plus_one(
    input logic [lmon_pkg::CNT_W-1:0] value
  );
    count_plus_one = {1'b0, value} + 17'h00001;
  endfunction : count_plus_one

  // ----------------------------------------------------------------------
  // Tick source
  // ----------------------------------------------------------------------
  lmon_tick u_tick (
    .clock_in    (clock_in),
    .reset_n_in  (reset_n_in),
    .fast_osc_in (fast_osc_in),
    .tick_bus    (tick_bus.source)
  );

  // Resolution steers the tick source
  assign tick_bus.fast_sel = fast_res_in;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  assign count_inc  = count_plus_one(count);
  assign expire_hit = tick_bus.tick && (count_inc >= {1'b0, interval_in});
  assign pulse_done = (pulse == 5'(PULSE_CYC - 1));

  // Next state and count
  always_comb begin
    next_state = state;
    next_count = count;
    unique case (state)
      lmon_pkg::LMON_IDLE: begin
        next_count = '0;
        if (enable_in) begin
          next_state = lmon_pkg::LMON_RUN;
        end
      end
      lmon_pkg::LMON_RUN: begin
        if (!enable_in) begin
          next_state = lmon_pkg::LMON_IDLE;
          next_count = '0;
        end else if (reload_in) begin
          next_count = '0;
        end else if (expire_hit) begin
          next_state = lmon_pkg::LMON_FIRE;
          next_count = '0;
        end else if (tick_bus.tick) begin
          next_count = count_inc[lmon_pkg::CNT_W-1:0];
        end
      end
      lmon_pkg::LMON_FIRE: begin
        next_count = '0;
        if (pulse_done) begin
          next_state = lmon_pkg::LMON_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // State, pulse and flag registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= lmon_pkg::LMON_IDLE;
      count <= lmon_pkg::COUNT_RST;
      pulse <= lmon_pkg::PULSE_RST;
    end else begin
      state <= next_state;
      count <= next_count;
      pulse <= (state == lmon_pkg::LMON_FIRE) ? pulse + 1'b1 : lmon_pkg::PULSE_RST;
    end
  end

  // Expiry flag: set wins over clear
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      expiry <= 1'b0;
    end else if (state == lmon_pkg::LMON_RUN && next_state == lmon_pkg::LMON_FIRE) begin
      expiry <= 1'b1;
    end else if (irq_clear_in) begin
      expiry <= 1'b0;
    end
  end

  // Registered outputs
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sys_reset_out  <= 1'b0;
      expiry_irq_out <= 1'b0;
      host_wr_ok_out <= 1'b0;
      count_out      <= '0;
    end else begin
      sys_reset_out  <= (next_state == lmon_pkg::LMON_FIRE);
      expiry_irq_out <= expiry;
      host_wr_ok_out <= host_wr_in && !expiry;
      count_out      <= count;
    end
  end

  // Length of the forced reset pulse so far, for the pulse assertions
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pulse_seen <= 6'h00;
    end else begin
      pulse_seen <= sys_reset_out ? pulse_seen + 1'b1 : 6'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  a_fire_sets_irq: assert property (
    (state == lmon_pkg::LMON_RUN && next_state == lmon_pkg::LMON_FIRE) |=> ##1 expiry_irq_out)
    else $error("expiry interrupt not raised after forced reset");

  a_write_blocked: assert property (
    expiry |=> !host_wr_ok_out)
    else $error("host write accepted while expiry pending");

  a_write_pass: assert property (
    (host_wr_in && !expiry) |=> host_wr_ok_out)
    else $error("host write dropped without pending expiry");

  a_reset_pulse_len: assert property (
    $rose(sys_reset_out) |-> sys_reset_out [*8])
    else $error("forced reset pulse too short");

  a_disabled_quiet: assert property (
    (!enable_in && state != lmon_pkg::LMON_FIRE) |=> !$rose(sys_reset_out))
    else $error("reset raised while monitor disabled");

  a_reload_zero: assert property (
    (state == lmon_pkg::LMON_RUN && enable_in && reload_in) |=> count == '0)
    else $error("reload did not restart count");

  a_expire_fires: assert property (
    (state == lmon_pkg::LMON_RUN && enable_in && !reload_in && expire_hit)
      |=> state == lmon_pkg::LMON_FIRE)
    else $error("interval elapsed without forced reset");

  a_idle_count: assert property (
    (state == lmon_pkg::LMON_IDLE) |=> count == '0)
    else $error("count moved while idle");

  a_pulse_exact: assert property (
    $fell(sys_reset_out) |-> pulse_seen == 6'(PULSE_CYC))
    else $error("forced reset pulse length wrong");

  a_pulse_bound: assert property (
    pulse_seen <= 6'(PULSE_CYC))
    else $error("forced reset pulse too long");

  a_irq_holds: assert property (
    $fell(expiry_irq_out) |-> $past(irq_clear_in, 2))
    else $error("expiry interrupt dropped without a clear");

  c_fire:    cover property ($rose(sys_reset_out));
  c_reload:  cover property (state == lmon_pkg::LMON_RUN && reload_in && count != '0);
  c_blocked: cover property (host_wr_in && expiry);
  c_fast:    cover property (fast_res_in && tick_bus.tick);
  c_clear:   cover property ($fell(expiry_irq_out));

endmodule : lmon_top

/* verif/tb_top.sv */
// Self-checking bench of the liveness monitor
`timescale 1ns/1ps
module tb_top;
  logic        clock_in, reset_n_in, enable_in, fast_res_in, reload_in;
  logic        irq_clear_in, fast_osc_in, host_wr_in, osc_run, seen_fire;
  logic [15:0] interval_in;
  logic        host_wr_ok_out, sys_reset_out, expiry_irq_out;
  logic [15:0] count_out;
  int          mismatches, checks, n, len, exp_irq, ival;
  logic        exp_q[$];

  lmon_top u_dut (.clock_in(clock_in), .reset_n_in(reset_n_in), .enable_in(enable_in),
    .fast_res_in(fast_res_in), .interval_in(interval_in), .reload_in(reload_in),
    .irq_clear_in(irq_clear_in), .fast_osc_in(fast_osc_in), .host_wr_in(host_wr_in),
    .host_wr_ok_out(host_wr_ok_out), .sys_reset_out(sys_reset_out),
    .expiry_irq_out(expiry_irq_out), .count_out(count_out));

  // Clock, 50 ns period
  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end

  // Fast oscillator, eight clocks a period, only while osc_run is set
  initial begin
    fast_osc_in = 1'b0;
    #100;
    forever #200 fast_osc_in = osc_run ? ~fast_osc_in : 1'b0;
  end

  // Watchdog against a hang
  initial begin
    #(50 * 20000);
    mismatches++;
    summarize();
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Wait a bounded count for the forced reset
  task automatic wait_fire(input int lim);
    n = 0;
    while (sys_reset_out !== 1'b1 && n < lim) begin
      @(negedge clock_in);
      n++;
    end
  endtask : wait_fire

  // Pulse shape of the forced reset and the flag behind it
  task automatic fire_check;
    enable_in = 1'b0;
    check("irq before", expiry_irq_out, 16'h0);
    len = 0;
    while (sys_reset_out === 1'b1 && len < 40) begin
      @(negedge clock_in);
      len++;
      if (len == 1) check("irq set", expiry_irq_out, 16'h1);
    end
    check("reset length", 16'(len), 16'h0010);
    exp_irq = 1;
  endtask : fire_check

  // Random host writes against the model
  task automatic writes;
    repeat (8) begin
      host_wr_in = 1'($urandom_range(1, 0));
      exp_q.push_back(host_wr_in & (exp_irq == 0));
      @(negedge clock_in);
      check("write pass", host_wr_ok_out, exp_q.pop_front());
    end
    host_wr_in = 1'b0;
  endtask : writes

  task automatic watch(input int cyc);
    repeat (cyc) begin
      @(negedge clock_in);
      seen_fire |= sys_reset_out;
    end
  endtask : watch

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize

  // Main sequence
  initial begin
    void'($urandom(32'h2A837C30));
    {reset_n_in, enable_in, fast_res_in, reload_in, irq_clear_in} = 5'h00;
    {host_wr_in, osc_run, seen_fire} = 3'h0;
    interval_in = 16'h0014;
    exp_irq = 0;
    repeat (6) @(posedge clock_in);
    @(negedge clock_in);
    reset_n_in = 1'b1;
    check("reset out", {sys_reset_out, expiry_irq_out, host_wr_ok_out}, 16'h0);
    // Reloads hold off the expiry
    fast_res_in = 1'b1;
    osc_run = 1'b1;
    enable_in = 1'b1;
    repeat (6) begin
      watch(60);
      reload_in = 1'b1;
      watch(1);
      reload_in = 1'b0;
      watch(2);
      check("count after reload", 16'(count_out < 16'h0002), 16'h1);
    end
    check("no fire reloaded", seen_fire, 16'h0);
    $display("test reload done");
    // Disabled monitor stays idle
    enable_in = 1'b0;
    watch(400);
    check("no fire disabled", seen_fire, 16'h0);
    check("count disabled", count_out, 16'h0);
    writes();
    $display("test disabled done");
    // Fast resolution expiry, then the write gate
    ival = $urandom_range(9, 2);
    interval_in = 16'(ival);
    enable_in = 1'b1;
    wait_fire(200);
    check("fast fire time", 16'(n >= 8 * ival - 6 && n <= 8 * ival + 1), 16'h1);
    fire_check();
    writes();
    irq_clear_in = 1'b1;
    @(negedge clock_in);
    irq_clear_in = 1'b0;
    exp_irq = 0;
    // The interrupt output trails the flag by one cycle
    @(negedge clock_in);
    check("irq cleared", expiry_irq_out, 16'h0);
    writes();
    $display("test fast done");
    // Slow resolution expiry on the first slow tick
    osc_run = 1'b0;
    fast_res_in = 1'b0;
    interval_in = 16'h0001;
    enable_in = 1'b1;
    wait_fire(1100);
    check("slow fire time", 16'(n >= 2 && n <= 1001), 16'h1);
    fire_check();
    writes();
    $display("test slow done");
    summarize();
  end
endmodule : tb_top
